// *** dv/hub_mode_stage_sequencer_tb.sv ***
// bench for the hub mode stage sequencer: mode pins, stages, axi4-lite
// assumes small stage counts: init 20, config 50, detection 30 cycles
`timescale 1ns/10ps
module hub_mode_stage_sequencer_tb;
   logic aclk = 1'h0, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, hub_reset_n, bypass_sel_n, ref_on;
   logic ref_clock_in, pll_locked, soc_handshake, bypass_switch_on, regulator_en;
   logic chgdet_run, upstream_dplus_line, int_n_oe, core_logic_reset, pll_enable, int_n_out;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, serial_addr_select, ref_freq_select, chg_result;
   int num_errors = 0, samples_checked = 0, cyc = 0;
   always #50 aclk = ~aclk;
   soc_clock_model u_soc (.aclk, .ref_on, .ref_clock_in, .pll_locked);
   hub_mode_stage_sequencer #(.INIT_CYCLES(20), .CONFIG_CYCLES(50), .CHGDET_CYCLES(30)) u_dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .hub_reset_n, .bypass_sel_n, .serial_addr_select, .ref_freq_select,
      .ref_clock_in, .pll_locked, .chg_result, .soc_handshake, .bypass_switch_on,
      .regulator_en, .core_logic_reset, .pll_enable, .chgdet_run,
      .upstream_dplus_line, .int_n_out, .int_n_oe);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task automatic chk(input string s, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic pk(input string s, input logic e, g);
      chk(s, {31'h0, e}, {31'h0, g});
   endtask : pk
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : wt
   task automatic mode(input logic r, b);
      @(posedge aclk);
      hub_reset_n <= r;
      bypass_sel_n <= b;
   endtask : mode
   // master waits without a bound; only the bench timeout ends a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, da, dw, b;
      logic [1:0] r;
      da = 1'h0;
      dw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         #1 ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         da |= ta;
         dw |= tw;
      end while (!(da && dw));
      do begin
         #1 b = bvalid;
         r = bresp;
         @(posedge aclk);
      end while (!b);
      bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         #1 t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'h0;
      do begin
         #1 t = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end while (!t);
      rready <= 1'h0;
      chk("rresp", {30'h0, er}, {30'h0, r});
      chk("rdata", e, d & m);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_bypass;
      mode(1'h1, 1'h0);
      wt(3);
      pk("bypass_switch_on", 1'h1, bypass_switch_on);
      pk("regulator_en", 1'h0, regulator_en);
   endtask : t_bypass
   task automatic t_early;
      mode(1'h1, 1'h1);
      wt(2);
      pk("core_logic_reset", 1'h1, core_logic_reset);
      wt(1);
      pk("bypass_switch_on", 1'h0, bypass_switch_on);
      pk("regulator_en", 1'h1, regulator_en);
      pk("core_logic_reset", 1'h0, core_logic_reset);
      wt(70);
      pk("int_n_oe", 1'h1, int_n_oe);
      pk("int_n_out", 1'h0, int_n_out);
      rd(8'h08, 32'hffff_ffff, 32'h0000_0000, 2'h2);
      ref_on <= 1'h1;
      wt(12);
      rd(8'h08, 32'h0000_0f7f, 32'h0000_0608, 2'h0);
      pk("pll_enable", 1'h1, pll_enable);
   endtask : t_early
   task automatic t_hold;
      wr(8'h00, 32'h0000_0001, 2'h0);
      wr(8'h04, 32'h0000_0003, 2'h0);
      rd(8'h10, 32'hffff_ffff, 32'h0000_0000, 2'h2);
      wt(60);
      rd(8'h08, 32'h0000_007f, 32'h0000_0008, 2'h0);
      wr(8'h00, 32'h0000_0000, 2'h0);
      wt(2);
      pk("chgdet_run", 1'h1, chgdet_run);
      rd(8'h08, 32'h0000_007f, 32'h0000_0010, 2'h0);
      wt(35);
      rd(8'h08, 32'h0000_007f, 32'h0000_0020, 2'h0);
      pk("upstream_dplus_line", 1'h0, upstream_dplus_line);
      wr(8'h00, 32'h0000_0002, 2'h0);
      wt(1);
      pk("upstream_dplus_line", 1'h1, upstream_dplus_line);
      wt(12);
      pk("upstream_dplus_line", 1'h1, upstream_dplus_line);
      rd(8'h08, 32'hffff_ffff, 32'h0000_0000, 2'h2);
      mode(1'h0, 1'h1);
      wt(3);
      pk("upstream_dplus_line", 1'h0, upstream_dplus_line);
      pk("regulator_en", 1'h0, regulator_en);
   endtask : t_hold
   task automatic t_default;
      mode(1'h1, 1'h1);
      wt(60);
      pk("upstream_dplus_line", 1'h0, upstream_dplus_line);
      wt(70);
      pk("upstream_dplus_line", 1'h1, upstream_dplus_line);
   endtask : t_default
   // reference returns during early detection, then the pin handshake connects
   task automatic t_pin;
      mode(1'h0, 1'h1);
      ref_on <= 1'h0;
      wt(3);
      mode(1'h1, 1'h1);
      wt(27);
      pk("chgdet_run", 1'h1, chgdet_run);
      pk("pll_enable", 1'h0, pll_enable);
      @(posedge aclk);
      ref_on <= 1'h1;
      wt(12);
      pk("int_n_oe", 1'h0, int_n_oe);
      wr(8'h04, 32'h0000_0007, 2'h0);
      wt(80);
      pk("upstream_dplus_line", 1'h0, upstream_dplus_line);
      @(posedge aclk);
      soc_handshake <= 1'h1;
      wt(1);
      pk("upstream_dplus_line", 1'h1, upstream_dplus_line);
   endtask : t_pin
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard: far above the few hundred cycles the scenarios need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      {aresetn, hub_reset_n, bypass_sel_n, ref_on, soc_handshake} <= 5'h00;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      {awaddr, araddr, wdata, wstrb} <= 52'h0;
      serial_addr_select <= 2'h2;
      ref_freq_select <= 2'h1;
      chg_result <= 2'h1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_bypass();
      t_early();
      t_hold();
      t_default();
      t_pin();
      results();
   end
endmodule : hub_mode_stage_sequencer_tb

// *** dv/soc_clock_model.sv ***
// soc side model: reference clock and pll lock indication
// assumes aclk is the bench clock and ref_on comes from the bench
`timescale 1ns/10ps
module soc_clock_model (
   // clock
   input  wire logic aclk,
   // control
   input  wire logic ref_on,
   // clock status
   output logic      ref_clock_in,
   output logic      pll_locked
);
   logic [2:0] lock_cnt = 3'h0;
   initial ref_clock_in = 1'h0;
   initial pll_locked = 1'h0;
   // reference stands still low while off, so no stale toggle looks active
   always @(posedge aclk) begin
      ref_clock_in <= ref_on ? ~ref_clock_in : 1'h0;
      lock_cnt <= ref_on ? lock_cnt + 3'(lock_cnt != 3'h7) : 3'h0;
      pll_locked <= (lock_cnt >= 3'h6);
   end
endmodule : soc_clock_model

// *** logic/hub_mode_stage_sequencer.sv ***
// hub mode stage sequencer with an axi4-lite register slave
// assumes mode pins and straps synchronous to aclk; aclk is pll or ring osc
`timescale 1ns/10ps
`include "seq_defs.svh"
module hub_mode_stage_sequencer #(
   parameter int INIT_CYCLES   = `INIT_TIME_MS * `CLK_PER_MS,
   parameter int CONFIG_CYCLES = `CONFIG_TIMEOUT_MS * `CLK_PER_MS,
   parameter int CHGDET_CYCLES = `CHGDET_TIME_MS * `CLK_PER_MS
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // mode pins and straps
   input  wire logic        hub_reset_n,
   input  wire logic        bypass_sel_n,
   input  wire logic [1:0]  serial_addr_select,
   input  wire logic [1:0]  ref_freq_select,
   // clocking status
   input  wire logic        ref_clock_in,
   input  wire logic        pll_locked,
   // charger detector and soc handshake
   input  wire logic [1:0]  chg_result,
   input  wire logic        soc_handshake,
   // power, switch and link controls
   output logic             bypass_switch_on,
   output logic             regulator_en,
   output logic             core_logic_reset,
   output logic             pll_enable,
   output logic             chgdet_run,
   output logic             upstream_dplus_line,
   // open-drain interrupt
   output logic             int_n_out,
   output logic             int_n_oe
);

   ////////////////////////////////////////////////////////////////////////
   function automatic seq_pkg::mode_t decode_mode(logic rst_n, logic byp_n);
      if (rst_n && byp_n)
         return seq_pkg::mode_hub;
      else if (rst_n)
         return seq_pkg::mode_bypass;
      return seq_pkg::mode_standby;
   endfunction : decode_mode

   function automatic logic serial_ok(seq_pkg::stage_t st);
      return st inside {seq_pkg::stage_config, seq_pkg::stage_charger_detect,
                        seq_pkg::stage_connect};
   endfunction : serial_ok

   function automatic logic mapped(logic [7:0] a);
      return a inside {`ADDR_INTERLOCK, `ADDR_HUBCFG, `ADDR_STATUS, `ADDR_EVENT};
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////
   seq_pkg::mode_t    mode;
   seq_pkg::stage_t   stage;
   seq_pkg::stage_t   next_stage;
   seq_pkg::hub_cfg_t cfg;
   seq_pkg::straps_t  straps;
   logic                is_hub;
   logic                ref_q;
   logic                ref_q2;
   logic [4:0]          ref_cnt;
   logic                ref_active;
   logic                ilk_hold;
   logic                ilk_go;
   logic                hold_seen;
   logic                hs_q;
   logic                hs_evt;
   logic                early_run;
   logic                early_tried;
   logic                early_start;
   logic                early_evt;
   logic [1:0]          det_res;
   logic                tmr_load;
   logic                tmr_abort;
   logic [`TIMER_W-1:0] tmr_value;
   logic                tmr_running;
   logic                tmr_done;
   logic                aw_full;
   logic                w_full;
   logic [7:0]          awaddr_q;
   logic [31:0]         wdata_q;
   logic                wstrb0_q;
   logic                wr_fire;
   logic                wr_ok;
   logic [31:0]         rd_word;

   assign is_hub     = (mode == seq_pkg::mode_hub);
   assign ref_active = (ref_cnt != 5'h00);
   assign hs_evt     = cfg.hs_sel ? (soc_handshake && !hs_q) : ilk_go;
   assign wr_fire    = aw_full && w_full && !bvalid;
   // refused when the serial port is not usable in the current stage
   assign wr_ok      = wr_fire && serial_ok(stage) && mapped(awaddr_q) && wstrb0_q;

   stage_timer u_timer (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (tmr_load),
      .abort      (tmr_abort),
      .load_value (tmr_value),
      .running    (tmr_running),
      .done       (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode pins and reference activity
   always_ff @(posedge aclk) begin
      if (!aresetn)
         mode <= seq_pkg::mode_standby;
      else
         mode <= decode_mode(hub_reset_n, bypass_sel_n);
   end

   // a reference that stops toggling reads inactive after a short window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_q   <= 1'b0;
         ref_q2  <= 1'b0;
         ref_cnt <= 5'h00;
         hs_q    <= 1'b0;
      end else begin
         ref_q  <= ref_clock_in;
         ref_q2 <= ref_q;
         hs_q   <= soc_handshake;
         if (ref_q != ref_q2)
            ref_cnt <= `REF_IDLE_CYCLES;
         else if (ref_cnt != 5'h00)
            ref_cnt <= ref_cnt - 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage sequence; the timer runs on aclk, itself the pll or ring osc
   always_comb begin
      next_stage  = stage;
      tmr_load    = 1'b0;
      tmr_abort   = 1'b0;
      tmr_value   = '0;
      early_start = 1'b0;
      if (!is_hub) begin
         next_stage = seq_pkg::stage_idle;
         tmr_abort  = 1'b1;
      end else begin
         unique case (stage)
            seq_pkg::stage_idle: begin
               next_stage = seq_pkg::stage_init;
               tmr_load   = 1'b1;
               tmr_value  = `TIMER_W'(INIT_CYCLES);
            end
            seq_pkg::stage_init: begin
               if (tmr_done)
                  next_stage = seq_pkg::stage_wait_reference;
            end
            seq_pkg::stage_wait_reference: begin
               if (ref_active && pll_locked) begin
                  next_stage = seq_pkg::stage_config;
                  tmr_load   = 1'b1;
                  tmr_value  = `TIMER_W'(CONFIG_CYCLES);
               end else if (early_run && pll_locked) begin
                  tmr_abort = 1'b1;
               end else if (!ref_active && cfg.chgdet_en && !early_run && !early_tried) begin
                  early_start = 1'b1;
                  tmr_load    = 1'b1;
                  tmr_value   = `TIMER_W'(CHGDET_CYCLES);
               end
            end
            seq_pkg::stage_config: begin
               // once held, the timeout no longer applies
               if (!ilk_hold && (hold_seen || tmr_done)) begin
                  next_stage = seq_pkg::stage_charger_detect;
                  tmr_load   = cfg.chgdet_en;
                  tmr_value  = `TIMER_W'(CHGDET_CYCLES);
               end
            end
            seq_pkg::stage_charger_detect: begin
               if (!cfg.chgdet_en || tmr_done)
                  next_stage = seq_pkg::stage_connect;
            end
            seq_pkg::stage_connect: begin
               if (!upstream_dplus_line && (!cfg.connect_wait || hs_evt)) begin
                  tmr_load  = 1'b1;
                  tmr_value = `TIMER_W'(`CONNECT_CYCLES);
               end else if (upstream_dplus_line && tmr_done) begin
                  next_stage = seq_pkg::stage_comm;
               end
            end
            seq_pkg::stage_comm: begin
               next_stage = seq_pkg::stage_comm;
            end
            default: begin
               next_stage = seq_pkg::stage_idle;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         stage <= seq_pkg::stage_idle;
      else
         stage <= next_stage;
   end

   ////////////////////////////////////////////////////////////////////////
   // early detection while the reference is missing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         early_run   <= 1'b0;
         early_tried <= 1'b0;
      end else if (stage != seq_pkg::stage_wait_reference || !is_hub) begin
         early_run   <= 1'b0;
         early_tried <= 1'b0;
      end else if (early_start) begin
         early_run   <= 1'b1;
         early_tried <= 1'b1;
      end else if (pll_locked || tmr_done) begin
         early_run <= 1'b0;
      end
   end

   // results kept only when the early run ends on its own; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         early_evt <= 1'b0;
         det_res   <= 2'h0;
      end else if (stage == seq_pkg::stage_idle) begin
         early_evt <= 1'b0;
         det_res   <= 2'h0;
      end else if (early_run && tmr_done && !pll_locked) begin
         early_evt <= 1'b1;
         det_res   <= chg_result;
      end else begin
         if (stage == seq_pkg::stage_charger_detect && tmr_done)
            det_res <= chg_result;
         if (wr_ok && awaddr_q == `ADDR_EVENT && wdata_q[`EVT_EARLY_BIT])
            early_evt <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers; defaults reload on every pass through idle
   always_ff @(posedge aclk) begin
      if (!aresetn || stage == seq_pkg::stage_idle) begin
         ilk_hold         <= `ILK_HOLD_RST;
         ilk_go           <= 1'b0;
         cfg.chgdet_en    <= `CFG_CHGDET_RST;
         cfg.connect_wait <= `CFG_WAIT_RST;
         cfg.hs_sel       <= `CFG_HSSEL_RST;
      end else begin
         ilk_go <= 1'b0;
         if (wr_ok && awaddr_q == `ADDR_INTERLOCK) begin
            ilk_hold <= wdata_q[`ILK_HOLD_BIT];
            ilk_go   <= wdata_q[`ILK_GO_BIT];
         end
         if (wr_ok && awaddr_q == `ADDR_HUBCFG) begin
            cfg.chgdet_en    <= wdata_q[`CFG_CHGDET_BIT];
            cfg.connect_wait <= wdata_q[`CFG_WAIT_BIT];
            cfg.hs_sel       <= wdata_q[`CFG_HSSEL_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         hold_seen <= 1'b0;
      else if (stage != seq_pkg::stage_config)
         hold_seen <= 1'b0;
      else if (ilk_hold)
         hold_seen <= 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         straps <= '0;
      else if (stage == seq_pkg::stage_idle && is_hub)
         straps <= {ref_freq_select, serial_addr_select};
   end

   ////////////////////////////////////////////////////////////////////////
   // pin outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bypass_switch_on    <= 1'b0;
         regulator_en        <= 1'b0;
         core_logic_reset    <= 1'b0;
         pll_enable          <= 1'b0;
         chgdet_run          <= 1'b0;
         upstream_dplus_line <= 1'b0;
         int_n_out           <= 1'b0;
         int_n_oe            <= 1'b0;
      end else begin
         bypass_switch_on <= (mode == seq_pkg::mode_bypass);
         regulator_en     <= is_hub;
         core_logic_reset <= is_hub && stage == seq_pkg::stage_idle;
         pll_enable       <= is_hub && ref_active;
         chgdet_run       <= early_run ||
                             (stage == seq_pkg::stage_charger_detect && tmr_running);
         int_n_oe         <= early_evt;
         if (stage == seq_pkg::stage_idle)
            upstream_dplus_line <= 1'b0;
         else if (stage == seq_pkg::stage_connect && tmr_load)
            upstream_dplus_line <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= `RESP_OKAY;
         aw_full  <= 1'b0;
         w_full   <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_full  <= 1'b1;
            awready  <= 1'b0;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_full   <= 1'b1;
            wready   <= 1'b0;
            wdata_q  <= wdata;
            wstrb0_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (serial_ok(stage) && mapped(awaddr_q)) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (araddr)
         `ADDR_INTERLOCK: rd_word = 32'(ilk_hold) << `ILK_HOLD_BIT;
         `ADDR_HUBCFG:    rd_word = (32'(cfg.chgdet_en) << `CFG_CHGDET_BIT) |
                                    (32'(cfg.connect_wait) << `CFG_WAIT_BIT) |
                                    (32'(cfg.hs_sel) << `CFG_HSSEL_BIT);
         `ADDR_STATUS:    rd_word = (32'(stage) << `STAT_STAGE_LSB) |
                                    (32'(straps) << `STAT_STRAP_LSB) |
                                    (32'(ref_active) << `STAT_REFACT_BIT) |
                                    (32'(pll_locked) << `STAT_LOCK_BIT) |
                                    (32'(det_res) << `STAT_RES_LSB) |
                                    (32'(early_evt) << `STAT_EARLY_BIT);
         `ADDR_EVENT:     rd_word = 32'(early_evt) << `EVT_EARLY_BIT;
         default:         rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         if (serial_ok(stage) && mapped(araddr)) begin
            rdata <= rd_word;
            rresp <= `RESP_OKAY;
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_handshake;
      stage == seq_pkg::stage_connect && !upstream_dplus_line && tmr_load;
   endsequence

   sequence s_connected;
      upstream_dplus_line ##[1:12] stage == seq_pkg::stage_comm;
   endsequence

   a_switch_off_hub: assert property (is_hub |=> !bypass_switch_on)
      else $error("bypass switch on in hub mode");
   a_mode_decode: assert property (hub_reset_n && !bypass_sel_n ##1 1 |=> bypass_switch_on)
      else $error("bypass pins did not select bypass");
   a_init_exit: assert property (stage == seq_pkg::stage_init && tmr_done && is_hub
      |=> stage == seq_pkg::stage_wait_reference)
      else $error("init did not end on timer");
   a_waitref_serial: assert property (arvalid && arready && stage inside
      {seq_pkg::stage_wait_reference, seq_pkg::stage_comm} |=> rvalid && rresp == `RESP_SLVERR)
      else $error("serial read answered in dead stage");
   a_waitref_exit: assert property (stage == seq_pkg::stage_wait_reference && is_hub
      && ref_active && pll_locked |=> stage == seq_pkg::stage_config)
      else $error("wait stage did not leave on lock");
   a_early_abort: assert property (early_run && pll_locked && !tmr_done
      |=> !early_run && !$rose(early_evt))
      else $error("early detection kept after lock");
   a_config_hold: assert property (stage == seq_pkg::stage_config && ilk_hold && is_hub
      |=> stage == seq_pkg::stage_config)
      else $error("config left while held");
   a_chgdet_skip: assert property (stage == seq_pkg::stage_charger_detect && !cfg.chgdet_en
      && is_hub |=> stage == seq_pkg::stage_connect)
      else $error("disabled detection not skipped");
   a_connect_seq: assert property (disable iff (!aresetn || !is_hub)
      s_handshake and is_hub |=> s_connected)
      else $error("connect did not reach communication");
   a_mode_exit: assert property (!is_hub |=> stage == seq_pkg::stage_idle)
      else $error("sequence not abandoned on mode exit");

endmodule : hub_mode_stage_sequencer

// *** logic/seq_defs.svh ***
// constants for the hub mode stage sequencer: timing, register map, fields
// assumes a 10 MHz aclk; every timer count is derived from the times below, the reference idle window is a fixed 16 cycles
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define CLK_PERIOD_NS             100
`define CLK_PER_MS                (1000000 / `CLK_PERIOD_NS)
`define INIT_TIME_MS              3
`define CONFIG_TIMEOUT_MS         400
`define CONTACT_DETECT_TIMEOUT_MS 10
`define SOURCE_ENABLE_TIME_MS     1
`define DETECT_END_DELAY_MS       1
`define CHGDET_TIME_MS            (`CONTACT_DETECT_TIMEOUT_MS + 2 * `SOURCE_ENABLE_TIME_MS + `DETECT_END_DELAY_MS)
`define CONNECT_DELAY_NS          1000
`define CONNECT_CYCLES            (`CONNECT_DELAY_NS / `CLK_PERIOD_NS)
`define REF_IDLE_CYCLES           5'h10
`define TIMER_W                   23

`define ADDR_INTERLOCK            8'h00
`define ADDR_HUBCFG               8'h04
`define ADDR_STATUS               8'h08
`define ADDR_EVENT                8'h0C

`define ILK_HOLD_BIT              0
`define ILK_GO_BIT                1
`define CFG_CHGDET_BIT            0
`define CFG_WAIT_BIT              1
`define CFG_HSSEL_BIT             2
`define EVT_EARLY_BIT             0
`define STAT_STAGE_LSB            0
`define STAT_STRAP_LSB            8
`define STAT_REFACT_BIT           12
`define STAT_LOCK_BIT             13
`define STAT_RES_LSB              14
`define STAT_EARLY_BIT            16

`define ILK_HOLD_RST              1'h0
`define CFG_CHGDET_RST            1'h1
`define CFG_WAIT_RST              1'h0
`define CFG_HSSEL_RST             1'h0

`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

// *** logic/seq_pkg.sv ***
// types used by the stage sequencer: stages, modes, config and straps
// assumes nothing beyond a SystemVerilog compiler
package seq_pkg;

   typedef enum logic [6:0] {
      stage_idle           = 7'h01,
      stage_init           = 7'h02,
      stage_wait_reference = 7'h04,
      stage_config         = 7'h08,
      stage_charger_detect = 7'h10,
      stage_connect        = 7'h20,
      stage_comm           = 7'h40
   } stage_t;

   typedef enum logic [2:0] {
      mode_standby = 3'h1,
      mode_bypass  = 3'h2,
      mode_hub     = 3'h4
   } mode_t;

   typedef struct packed {
      logic hs_sel;
      logic connect_wait;
      logic chgdet_en;
   } hub_cfg_t;

   typedef struct packed {
      logic [1:0] ref_sel;
      logic [1:0] addr_sel;
   } straps_t;

endpackage : seq_pkg

// *** logic/stage_timer.sv ***
// down counter that times init, config, charger detection, connect and the early detection run
// assumes aclk is the running core clock, pll or ring oscillator
`timescale 1ns/10ps
`include "seq_defs.svh"
module stage_timer (
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // control
   input  wire logic                load,
   input  wire logic                abort,
   input  wire logic [`TIMER_W-1:0] load_value,
   // status
   output logic                     running,
   output logic                     done
);
   logic [`TIMER_W-1:0] count;

   // load wins over abort so a load always restarts the count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count   <= '0;
         running <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            count   <= load_value;
            running <= 1'b1;
         end else if (abort) begin
            running <= 1'b0;
         end else if (running) begin
            count <= count - `TIMER_W'(1);
            if (count == `TIMER_W'(1)) begin
               running <= 1'b0;
               done    <= 1'b1;
            end
         end
      end
   end

endmodule : stage_timer
